// *** core/sdadc_pkg.sv ***
// constants, types and register map shared by the converter sequencer files
package sdadc_pkg;

    // ************************************************************
    // converter data path
    // ************************************************************
    localparam int          RES_W       = 12;
    localparam int          WIN_W       = 11;
    localparam int          SUM_W       = 13;
    localparam int          HIST_N      = 4;
    localparam logic [10:0] WIN_LEN_12  = 11'h0400;
    localparam logic [10:0] WIN_LEN_8   = 11'h0040;
    localparam logic [12:0] SAT_12      = 13'h0FFF;
    localparam logic [12:0] SAT_8       = 13'h00FF;
    localparam logic [2:0]  PRIME_CONV  = 3'h3;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_MULTI,
        MODE_CONT,
        MODE_TURBO
    } mode_e;

    // ************************************************************
    // controller register map (byte addresses)
    // ************************************************************
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  OFS_CTRL       = 4'h0;
    localparam logic [3:0]  OFS_STATUS     = 4'h4;
    localparam logic [3:0]  OFS_MASK       = 4'h8;
    localparam logic [3:0]  OFS_RESULT     = 4'hC;
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          MODE_W         = 2;
    localparam int          CTRL_RES8_BIT  = 2;
    localparam int          CTRL_START_BIT = 3;
    localparam int          CTRL_STOP_BIT  = 4;
    localparam int          ST_DONE_BIT    = 0;
    localparam int          ST_BUSY_BIT    = 1;
    localparam int          ST_EOC_BIT     = 2;

endpackage

// *** core/adc_link_if.sv ***
// link between the converter sequencer and its controlling end
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
    import sdadc_pkg::*;

    logic              start;
    logic              stop;
    mode_e             mode;
    logic              res8;
    logic              rd_ack;
    logic              eoc;
    logic              done_pulse;
    logic              busy;
    logic [RES_W-1:0]  result;

    modport dev (
        input  start,
        input  stop,
        input  mode,
        input  res8,
        input  rd_ack,
        output eoc,
        output done_pulse,
        output busy,
        output result
    );

    modport ctl (
        output start,
        output stop,
        output mode,
        output res8,
        output rd_ack,
        input  eoc,
        input  done_pulse,
        input  busy,
        input  result
    );
endinterface
`default_nettype wire

// *** core/sdadc_decimator.sv ***
// decimator: bit stream to words, output is the saturated sum of the last four windows
`timescale 1ns/1ns
`default_nettype none
module sdadc_decimator
    import sdadc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             clear,
    input  wire logic             bit_in,
    input  wire logic             res8,
    output logic                  win_done,
    output logic [RES_W-1:0]      sum_out
);

    typedef struct packed {
        logic [WIN_W-1:0]             win_cnt;
        logic [WIN_W-1:0]             ones;
        logic [HIST_N-1:0][WIN_W-1:0] hist;
        logic                         win_done;
        logic [RES_W-1:0]             sum;
    } dec_s;

    dec_s dec_reg;
    dec_s dec_next;

    // ************************************************************
    // window count, history shift and saturation
    // ************************************************************
    always_comb begin
        logic [WIN_W-1:0] last;
        logic [SUM_W-1:0] total;
        last = res8 ? WIN_LEN_8 - 11'h001 : WIN_LEN_12 - 11'h001;
        total = '0;
        dec_next = dec_reg;
        dec_next.win_done = 1'b0;
        if (clear) begin
            dec_next.win_cnt = '0;
            dec_next.ones = '0;
            dec_next.hist = '0;
        end else if (dec_reg.win_cnt == last) begin
            dec_next.win_cnt = '0;
            dec_next.ones = '0;
            dec_next.hist[0] = dec_reg.ones + WIN_W'(bit_in);
            for (int i = 1; i < HIST_N; i++) begin
                dec_next.hist[i] = dec_reg.hist[i-1];
            end
            // only the last four windows count
            for (int i = 0; i < HIST_N; i++) begin
                total = total + SUM_W'(dec_next.hist[i]);
            end
            if (res8) begin
                dec_next.sum = (total > SAT_8) ? RES_W'(SAT_8)
                                               : RES_W'(total);
            end else begin
                dec_next.sum = (total > SAT_12) ? RES_W'(SAT_12)
                                                : RES_W'(total);
            end
            dec_next.win_done = 1'b1;
        end else begin
            dec_next.win_cnt = dec_reg.win_cnt + 11'h001;
            dec_next.ones = dec_reg.ones + WIN_W'(bit_in);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dec_reg <= '0;
        end else if (ce) begin
            dec_reg <= dec_next;
        end
    end

    assign win_done = dec_reg.win_done;
    assign sum_out  = dec_reg.sum;

endmodule // sdadc_decimator
`default_nettype wire

// *** core/sdadc_dev.sv ***
// converter sequencer: modes, start, decimator priming, end of conversion
//
// Notes on behaviour
// - four modes: single, multi, continuous, turbo multi
// - start by start bit or trigger
// - done sets status, eoc high until read
// - single: standby, four conversions, result after fourth
// - single returns to standby after result read
// - continuous: prime three, then every window result
// - continuous mode meant for one input only
// - multi re-primes decimator, restarts automatically
// - result invalid until fourth sample after mux
// - 12-bit at 192 ksps, 8-bit faster
// - decimator turns bit stream into words
// - eoc pulses at every conversion end
// - host polls status or uses eoc interrupt
// - trigger may come from programmable_logic_block
// - trigger optional, unused in continuous mode; here a trigger edge in standby starts a run in any mode
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sdadc_dev
    import sdadc_pkg::*;
(
    input  wire logic  CLK_SYS,
    input  wire logic  SYS_RST,
    input  wire logic  CLK_EN,
    input  wire logic  MOD_BIT,
    input  wire logic  MUX_SWITCHED,
    input  wire logic  TRIG,
    adc_link_if.dev    link,
    output logic       EOC_PULSE,
    output logic       STANDBY
);

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_RUN,
        ST_HOLD
    } seq_e;

    typedef struct packed {
        seq_e              state;
        mode_e             mode;
        logic              res8;
        logic [2:0]        fill;
        logic              eoc;
        logic              pulse;
        logic              busy;
        logic              standby;
        logic              trig_prev;
        logic [RES_W-1:0]  result;
    } seq_s;

    seq_s              seq_reg;
    seq_s              seq_next;
    logic              dec_clear;
    logic              start_ev;
    logic              win_done;
    logic [RES_W-1:0]  dec_sum;

    // ************************************************************
    // decimator
    // ************************************************************
    sdadc_decimator u_dec (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .ce       (CLK_EN),
        .clear    (dec_clear),
        .bit_in   (MOD_BIT),
        .res8     (seq_reg.res8),
        .win_done (win_done),
        .sum_out  (dec_sum)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        seq_next = seq_reg;
        seq_next.pulse = 1'b0;
        seq_next.trig_prev = TRIG;
        dec_clear = 1'b0;
        // rising trigger edge or start bit; a tied-low trigger never fires
        start_ev = link.start | (TRIG & ~seq_reg.trig_prev);
        if (link.rd_ack) begin
            seq_next.eoc = 1'b0;
        end
        unique case (seq_reg.state)
            ST_STANDBY: begin
                if (start_ev) begin
                    seq_next.mode = link.mode;
                    seq_next.res8 = link.res8;
                    seq_next.fill = '0;
                    seq_next.state = ST_RUN;
                    seq_next.busy = 1'b1;
                    seq_next.standby = 1'b0;
                    dec_clear = 1'b1;
                end
            end
            ST_RUN: begin
                if (link.stop) begin
                    seq_next.state = ST_STANDBY;
                    seq_next.busy = 1'b0;
                    seq_next.standby = 1'b1;
                    dec_clear = 1'b1;
                end else if (MUX_SWITCHED) begin
                    // history holds old input until four new windows
                    seq_next.fill = '0;
                end else if (win_done) begin
                    if (seq_reg.fill != PRIME_CONV) begin
                        seq_next.fill = seq_reg.fill + 3'h1;
                    end else begin
                        seq_next.result = dec_sum;
                        seq_next.eoc = 1'b1;
                        seq_next.pulse = 1'b1;
                        unique case (seq_reg.mode)
                            MODE_SINGLE: begin
                                seq_next.state = ST_HOLD;
                                dec_clear = 1'b1;
                            end
                            MODE_CONT: begin
                                // stay primed: each later window is a result
                                seq_next.fill = PRIME_CONV;
                            end
                            MODE_MULTI, MODE_TURBO: begin
                                seq_next.fill = '0;
                                dec_clear = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_HOLD: begin
                if (link.rd_ack || !seq_reg.eoc || link.stop) begin
                    seq_next.state = ST_STANDBY;
                    seq_next.busy = 1'b0;
                    seq_next.standby = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            seq_reg <= '0;
            seq_reg.standby <= 1'b1;
        end else if (CLK_EN) begin
            seq_reg <= seq_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign link.eoc        = seq_reg.eoc;
    assign link.done_pulse = seq_reg.pulse;
    assign link.busy       = seq_reg.busy;
    assign link.result     = seq_reg.result;
    assign EOC_PULSE       = seq_reg.pulse;
    assign STANDBY         = seq_reg.standby;

endmodule // sdadc_dev
`default_nettype wire

// *** core/sdadc_ctl.sv ***
// controller end: Avalon-MM registers, start orders, result read, interrupt
`timescale 1ns/1ns
`default_nettype none
module sdadc_ctl
    import sdadc_pkg::*;
(
    input  wire logic               CLK_SYS,
    input  wire logic               SYS_RST,
    input  wire logic               CLK_EN,
    input  wire logic [ADDR_W-1:0]  AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    output logic      [31:0]        AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    output logic                    IRQ,
    adc_link_if.ctl                 link
);

    typedef struct packed {
        logic         ack;
        logic         waitreq;
        logic [31:0]  rdata;
        mode_e        mode;
        logic         res8;
        logic         start;
        logic         stop;
        logic         rd_ack;
        logic         done;
        logic         mask;
        logic         irq;
    } ctl_s;

    ctl_s ctl_reg;
    ctl_s ctl_next;
    logic req;
    logic fin;

    // ************************************************************
    // bus slave and registers
    // ************************************************************
    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.start = 1'b0;
        ctl_next.stop = 1'b0;
        ctl_next.rd_ack = 1'b0;
        req = AVS_READ | AVS_WRITE;
        fin = req & ctl_reg.ack;
        ctl_next.ack = req & ~ctl_reg.ack;
        ctl_next.waitreq = ~ctl_next.ack;
        if (req && !ctl_reg.ack) begin
            ctl_next.rdata = '0;
            unique case (AVS_ADDRESS)
                OFS_CTRL: begin
                    ctl_next.rdata[CTRL_MODE_LSB +: MODE_W] = ctl_reg.mode;
                    ctl_next.rdata[CTRL_RES8_BIT] = ctl_reg.res8;
                end
                OFS_STATUS: begin
                    ctl_next.rdata[ST_DONE_BIT] = ctl_reg.done;
                    ctl_next.rdata[ST_BUSY_BIT] = link.busy;
                    ctl_next.rdata[ST_EOC_BIT] = link.eoc;
                end
                OFS_MASK: begin
                    ctl_next.rdata[ST_DONE_BIT] = ctl_reg.mask;
                end
                OFS_RESULT: begin
                    ctl_next.rdata[RES_W-1:0] = link.result;
                end
                default: begin
                    ctl_next.rdata = '0;
                end
            endcase
        end
        if (fin && AVS_WRITE) begin
            unique case (AVS_ADDRESS)
                OFS_CTRL: begin
                    ctl_next.mode =
                        mode_e'(AVS_WRITEDATA[CTRL_MODE_LSB +: MODE_W]);
                    ctl_next.res8 = AVS_WRITEDATA[CTRL_RES8_BIT];
                    ctl_next.start = AVS_WRITEDATA[CTRL_START_BIT];
                    ctl_next.stop = AVS_WRITEDATA[CTRL_STOP_BIT];
                end
                OFS_STATUS: begin
                    if (AVS_WRITEDATA[ST_DONE_BIT]) begin
                        ctl_next.done = 1'b0;
                    end
                end
                OFS_MASK: begin
                    ctl_next.mask = AVS_WRITEDATA[ST_DONE_BIT];
                end
                default: begin
                    ctl_next.mask = ctl_reg.mask;
                end
            endcase
        end
        if (fin && AVS_READ && AVS_ADDRESS == OFS_RESULT) begin
            ctl_next.rd_ack = 1'b1;
        end
        // a completion in the clearing cycle still sets the flag
        if (link.done_pulse) begin
            ctl_next.done = 1'b1;
        end
        ctl_next.irq = ctl_next.done & ctl_next.mask;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ctl_reg <= '0;
            ctl_reg.waitreq <= 1'b1;
        end else if (CLK_EN) begin
            ctl_reg <= ctl_next;
        end
    end

    assign AVS_READDATA    = ctl_reg.rdata;
    assign AVS_WAITREQUEST = ctl_reg.waitreq;
    assign IRQ             = ctl_reg.irq;
    assign link.start      = ctl_reg.start;
    assign link.stop       = ctl_reg.stop;
    assign link.mode       = ctl_reg.mode;
    assign link.res8       = ctl_reg.res8;
    assign link.rd_ack     = ctl_reg.rd_ack;

endmodule // sdadc_ctl
`default_nettype wire

// *** dv/sdadc_chk.sv ***
// assertions on the converter-to-controller link
`timescale 1ns/1ns
`default_nettype none
module sdadc_chk
    import sdadc_pkg::*;
(
    input wire logic             CLK_SYS,
    input wire logic             SYS_RST,
    input wire logic             stop,
    input wire mode_e            mode,
    input wire logic             res8,
    input wire logic             rd_ack,
    input wire logic             eoc,
    input wire logic             done_pulse,
    input wire logic             busy,
    input wire logic [RES_W-1:0] result
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    // ********
    // run tracking: mode and width latched as busy rises
    // ********
    logic [12:0] since_reg;
    logic        first_reg;
    logic        res_reg;
    logic        busy_reg;
    mode_e       mode_reg;
    logic [12:0] win;

    assign win = res_reg ? 13'h0040 : 13'h0400;

    always_ff @(posedge CLK_SYS) begin
        busy_reg <= busy;
        if (SYS_RST || (busy && !busy_reg) || done_pulse) begin
            since_reg <= 13'h0;
        end else if (since_reg != 13'h1FFF) begin
            since_reg <= since_reg + 13'h1;
        end
        if (SYS_RST) begin
            first_reg <= 1'b0;
            res_reg   <= 1'b0;
            mode_reg  <= MODE_SINGLE;
        end else if (busy && !busy_reg) begin
            first_reg <= 1'b1;
            res_reg   <= res8;
            mode_reg  <= mode;
        end else if (done_pulse) begin
            first_reg <= 1'b0;
        end
    end

    property p_done_eoc; done_pulse |-> eoc && busy; endproperty
    a_done_eoc: assert property (p_done_eoc)
        else $error("result pulse without eoc");
    property p_eoc_hold; eoc && !rd_ack && !stop |=> eoc; endproperty
    a_eoc_hold: assert property (p_eoc_hold)
        else $error("eoc dropped before read");
    property p_eoc_clr; rd_ack && !done_pulse |=> !eoc || done_pulse;
    endproperty
    a_eoc_clr: assert property (p_eoc_clr)
        else $error("eoc kept after read");
    property p_pulse; done_pulse |=> !done_pulse; endproperty
    a_pulse: assert property (p_pulse)
        else $error("result pulse too long");
    property p_first;
        done_pulse && first_reg |->
            since_reg + 13'h3 >= 4 * win && since_reg <= 4 * win + 2;
    endproperty
    a_first: assert property (p_first)
        else $error("first result not after four windows");
    property p_cont;
        done_pulse && !first_reg && mode_reg == MODE_CONT |->
            since_reg + 13'h2 >= win;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous result too early");
    property p_multi;
        done_pulse && !first_reg && mode_reg inside {MODE_MULTI, MODE_TURBO}
            |-> since_reg + 13'h3 >= 4 * win;
    endproperty
    a_multi: assert property (p_multi)
        else $error("repeated result without priming");
    property p_single; done_pulse && mode_reg == MODE_SINGLE |-> first_reg;
    endproperty
    a_single: assert property (p_single)
        else $error("second result in single mode");
    property p_sgl_end; mode_reg == MODE_SINGLE && $fell(eoc) |-> !busy;
    endproperty
    a_sgl_end: assert property (p_sgl_end)
        else $error("no standby after read");
    property p_chg; $changed(result) |-> done_pulse; endproperty
    a_chg: assert property (p_chg)
        else $error("result moved without pulse");

    c_cont: cover property (done_pulse && mode_reg == MODE_CONT);
    c_turbo: cover property (done_pulse && mode_reg == MODE_TURBO);
    c_single: cover property ($fell(eoc) && mode_reg == MODE_SINGLE);
endmodule // sdadc_chk
`default_nettype wire

// *** dv/sigma_delta_adc_sequencer_tb_top.sv ***
// self-checking bench for converter sequencer and controller
`timescale 1ns/1ns
`default_nettype none
module sigma_delta_adc_sequencer_tb_top import sdadc_pkg::*; ;
    logic        clk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        mod_bit;
    logic        mux_switched;
    logic        trig;
    logic        eoc_pulse;
    logic        standby;
    logic [1:0]  pat;
    logic [31:0] rd;
    int          num_errors;
    int          n_tests;
    int          cycles;
    int          gap;

    adc_link_if link_bus();
    sdadc_dev sdadc_dev_inst (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(1'b1),
        .MOD_BIT(mod_bit), .MUX_SWITCHED(mux_switched), .TRIG(trig),
        .link(link_bus), .EOC_PULSE(eoc_pulse), .STANDBY(standby));
    sdadc_ctl sdadc_ctl_inst (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(1'b1),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
        .IRQ(irq), .link(link_bus));
    sdadc_chk sdadc_chk_inst (.CLK_SYS(clk), .SYS_RST(rst),
        .stop(link_bus.stop), .mode(link_bus.mode), .res8(link_bus.res8),
        .rd_ack(link_bus.rd_ack), .eoc(link_bus.eoc),
        .done_pulse(link_bus.done_pulse), .busy(link_bus.busy),
        .result(link_bus.result));

    always #25 clk = ~clk;

    // modulator stream: 0 zeros, 1 alternating, 2 ones
    always @(posedge clk) begin
        mod_bit <= (pat == 2'h2) | ((pat == 2'h1) & ~mod_bit);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ********
    // helpers
    // ********
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(logic wr, logic [3:0] a, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        // waitrequest and read data are taken at the rising edge itself
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk("bus", 32'h1, 32'(n < 20));
    endtask

    task automatic rdchk(string nm, logic [3:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic wait_pulse(int lim);
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (eoc_pulse !== 1'b1 && gap < lim);
    endtask

    task automatic pulse(logic is_trig);
        @(posedge clk);
        if (is_trig) trig <= 1'b1;
        else mux_switched <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        mux_switched <= 1'b0;
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_single();
        rdchk("status", OFS_STATUS, 32'h0);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        rdchk("unmapped", 4'h2, 32'h0);
        pat <= 2'h2;
        bus(1'b1, OFS_MASK, 32'h1);
        bus(1'b1, OFS_CTRL, 32'hC);
        wait_pulse(400);
        chk("prime", 32'h1, 32'(gap > 250 && gap < 270));
        rdchk("status", OFS_STATUS, 32'h7);
        chk("irq", 32'h1, 32'(irq));
        rdchk("result", OFS_RESULT, 32'hFF);
        rdchk("status", OFS_STATUS, 32'h1);
        bus(1'b1, OFS_STATUS, 32'h1);
        rdchk("ctrl", OFS_CTRL, 32'h4);
        chk("irq", 32'h0, 32'(irq));
        wait_pulse(300);
        chk("standby", 32'h1, 32'(standby && gap == 300));
        $display("test single done");
    endtask

    task automatic t_trig();
        pat <= 2'h1;
        bus(1'b1, OFS_MASK, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h4);
        pulse(1'b1);
        wait_pulse(400);
        chk("trig", 32'h1, 32'(gap < 400));
        repeat (2) @(negedge clk);
        chk("masked", 32'h0, 32'(irq));
        bus(1'b1, OFS_MASK, 32'h1);
        repeat (2) @(negedge clk);
        chk("irq", 32'h1, 32'(irq));
        rdchk("result", OFS_RESULT, 32'h80);
        bus(1'b1, OFS_STATUS, 32'h1);
        $display("test trig done");
    endtask

    task automatic t_cont();
        pat <= 2'h0;
        bus(1'b1, OFS_CTRL, 32'hE);
        wait_pulse(400);
        wait_pulse(100);
        chk("rate", 32'h40, 32'(gap));
        pulse(1'b0);
        wait_pulse(190);
        chk("mux hold", 32'h1, 32'(gap == 190));
        wait_pulse(100);
        chk("mux end", 32'h1, 32'(gap < 100));
        rdchk("result", OFS_RESULT, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h16);
        repeat (4) @(negedge clk);
        chk("stop", 32'h1, 32'(standby));
        bus(1'b1, OFS_STATUS, 32'h1);
        $display("test cont done");
    endtask

    task automatic t_multi();
        pat <= 2'h1;
        for (int i = 1; i < 4; i += 2) begin
            bus(1'b1, OFS_CTRL, 32'hC | i);
            wait_pulse(400);
            wait_pulse(300);
            chk("reprime", 32'h1, 32'(gap > 250 && gap < 262));
            rdchk("result", OFS_RESULT, 32'h80);
            bus(1'b1, OFS_CTRL, 32'h14 | i);
            bus(1'b1, OFS_STATUS, 32'h1);
            chk("stop", 32'h1, 32'(standby));
        end
        pat <= 2'h2;
        bus(1'b1, OFS_CTRL, 32'h8);
        wait_pulse(4200);
        chk("prime", 32'h1, 32'(gap > 4096 && gap < 4112));
        rdchk("result", OFS_RESULT, 32'h0FFF);
        $display("test multi done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {mod_bit, mux_switched, trig, pat} = '0;
        {num_errors, n_tests, cycles} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_single();
        t_trig();
        t_cont();
        t_multi();
        close_out();
    end
endmodule // sigma_delta_adc_sequencer_tb_top
`default_nettype wire
